// ### core/fsps_host.sv
// Host sequencer driving a flash self-programming unit: arms the
// control register, issues the store instruction and waits out stalls.
// Assumes device pins are reached directly and its inputs are async.
//
// Summary of operation
// - Host refuses to write a page from the buffer before it is erased.
// - Word field picks buffer word on load; host zeroes it on write.
// - Host only writes pages erased since their last write.
// - Host keeps pointer bit 0 at zero for store commands.
// - Erase: control value 00000011, store within four cycles.
// - Host masks interrupts around the timed control sequence.
// - Load: control value 00000001, store within four cycles.
// - Host never loads a buffer word twice without a clear.
// - Write: control value 00000101, store within four cycles.
// - Host waits for EEPROM busy clear before writing control.
`timescale 1ns/10ps
`include "fsps_defines.svh"

module fsps_host #(
  parameter int unsigned PROG_TIMEOUT = `FSPS_PROG_TIMEOUT
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // User command port
  input wire logic CMD_VALID,
  input wire fsps_pkg::fsps_cmd_s CMD,
  output logic CMD_READY,
  output logic DONE,
  output logic ERROR,
  output fsps_pkg::fsps_err_e ERR_CODE,
  output logic BUF_LOST,
  // Device side
  output logic SPM_CTRL_WE,
  output logic [7:0] SPM_CTRL_DATA,
  output logic SPM_STROBE,
  output logic [`FSPS_PTR_W-1:0] SPM_POINTER,
  output logic [15:0] SPM_DATA_PAIR,
  output logic IRQ_DISABLE,
  input wire logic CORE_STALL,
  input wire logic EE_BUSY,
  input wire logic SELF_PROG_FUSE_N
);

  typedef enum logic [3:0] {
    S_IDLE,
    S_CHECK,
    S_ARM,
    S_GAP,
    S_STRB,
    S_WSTALL,
    S_BUSY,
    S_SETTLE,
    S_FIN,
    S_FAIL
  } fsps_state_e;

  fsps_state_e state_r;
  fsps_pkg::fsps_cmd_s cmd_r;
  fsps_pkg::fsps_err_e err_nxt;
  logic [3:0] cnt_r;
  logic [`FSPS_TIMER_W-1:0] busy_cnt_r;
  logic stall_s;
  logic ee_busy_s;
  logic ee_idle_s;
  logic fuse_en_s;
  logic word_hit;
  logic page_ok;
  logic lost;
  logic trk_clr;
  logic trk_set;
  logic trk_erase;
  logic trk_write;
  logic [`FSPS_PTR_W-1:0] ptr_nxt;
  logic [7:0] ctrl_nxt;

  //////////////////////////////////////////////////////////////////////
  // Input synchronisation and state mirror

  fsps_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(CLK),
    .resetn(RESETN),
    .async_in({CORE_STALL, ~EE_BUSY, ~SELF_PROG_FUSE_N}),
    .sync_out({stall_s, ee_idle_s, fuse_en_s})
  );

  // Synced in inverted sense so that reset reads busy and fuse-disabled
  assign ee_busy_s = !ee_idle_s;

  fsps_track #(
    .WORD_BITS(`FSPS_WORD_W),
    .PAGE_BITS(`FSPS_PAGE_W)
  ) u_track (
    .clk(CLK),
    .resetn(RESETN),
    .clr_words(trk_clr),
    .set_word(trk_set),
    .erase_blk(trk_erase),
    .wr_page(trk_write),
    .ee_busy(ee_busy_s),
    .word_idx(cmd_r.word),
    .page_idx(cmd_r.page),
    .word_hit(word_hit),
    .page_ok(page_ok),
    .lost(lost)
  );

  //////////////////////////////////////////////////////////////////////
  // Command decode

  always_comb begin
    ptr_nxt = '0;
    ctrl_nxt = `FSPS_CTRL_IDLE;
    unique case (cmd_r.op)
      fsps_pkg::FSPS_OP_LOAD: begin
        ctrl_nxt = `FSPS_CTRL_LOAD;
        ptr_nxt[`FSPS_PTR_PAGE_LSB-1:`FSPS_PTR_WORD_LSB] = cmd_r.word;
        ptr_nxt[`FSPS_PTR_PAGE_LSB+`FSPS_PAGE_W-1:`FSPS_PTR_PAGE_LSB] =
          cmd_r.page;
      end
      fsps_pkg::FSPS_OP_ERASE: begin
        ctrl_nxt = `FSPS_CTRL_ERASE;
        ptr_nxt[`FSPS_PTR_PAGE_LSB+`FSPS_PAGE_W-1:`FSPS_PTR_PAGE_LSB] =
          {cmd_r.page[`FSPS_PAGE_W-1:`FSPS_BLOCK_LOW_W],
           {`FSPS_BLOCK_LOW_W{1'b0}}};
      end
      fsps_pkg::FSPS_OP_WRITE: begin
        ctrl_nxt = `FSPS_CTRL_WRITE;
        // Word field and bit 0 stay zero for a page write
        ptr_nxt[`FSPS_PTR_PAGE_LSB+`FSPS_PAGE_W-1:`FSPS_PTR_PAGE_LSB] =
          cmd_r.page;
      end
      fsps_pkg::FSPS_OP_CLEAR: begin
        ctrl_nxt = `FSPS_CTRL_CLEAR;
      end
    endcase
  end

  // Refusals checked before anything reaches the device
  always_comb begin
    err_nxt = fsps_pkg::FSPS_ERR_NONE;
    if (!fuse_en_s) begin
      err_nxt = fsps_pkg::FSPS_ERR_FUSE;
    end else if (cmd_r.op == fsps_pkg::FSPS_OP_WRITE && !page_ok) begin
      err_nxt = fsps_pkg::FSPS_ERR_NOT_ERASED;
    end else if (cmd_r.op == fsps_pkg::FSPS_OP_LOAD && word_hit) begin
      err_nxt = fsps_pkg::FSPS_ERR_DUP_WORD;
    end
  end

  // Mirror updates follow what the device does to its own buffer
  always_comb begin
    trk_set = (state_r == S_STRB) && (cmd_r.op == fsps_pkg::FSPS_OP_LOAD);
    trk_erase = (state_r == S_BUSY) && !stall_s &&
                (cmd_r.op == fsps_pkg::FSPS_OP_ERASE);
    trk_write = (state_r == S_BUSY) && !stall_s &&
                (cmd_r.op == fsps_pkg::FSPS_OP_WRITE);
    trk_clr = trk_write ||
              ((state_r == S_SETTLE) && (cnt_r == 4'(`FSPS_ARM_WINDOW)));
  end

  //////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= S_IDLE;
      cmd_r <= '0;
      cnt_r <= '0;
      busy_cnt_r <= '0;
      ERR_CODE <= fsps_pkg::FSPS_ERR_NONE;
    end else begin
      unique case (state_r)
        S_IDLE: begin
          if (CMD_VALID) begin
            cmd_r <= CMD;
            state_r <= S_CHECK;
          end
        end
        S_CHECK: begin
          if (err_nxt != fsps_pkg::FSPS_ERR_NONE) begin
            ERR_CODE <= err_nxt;
            state_r <= S_FAIL;
          end else if (!ee_busy_s) begin
            state_r <= S_ARM;
          end
        end
        S_ARM: begin
          cnt_r <= '0;
          if (cmd_r.op == fsps_pkg::FSPS_OP_CLEAR) begin
            state_r <= S_SETTLE;
          end else begin
            state_r <= S_GAP;
          end
        end
        S_GAP: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'(`FSPS_ARM_GAP - 1)) begin
            state_r <= S_STRB;
          end
        end
        S_STRB: begin
          cnt_r <= '0;
          if (cmd_r.op == fsps_pkg::FSPS_OP_LOAD) begin
            state_r <= S_FIN;
          end else begin
            state_r <= S_WSTALL;
          end
        end
        S_WSTALL: begin
          cnt_r <= cnt_r + 4'h1;
          busy_cnt_r <= '0;
          if (stall_s) begin
            state_r <= S_BUSY;
          end else if (cnt_r == 4'(`FSPS_STALL_WAIT)) begin
            ERR_CODE <= fsps_pkg::FSPS_ERR_NO_STALL;
            state_r <= S_FAIL;
          end
        end
        S_BUSY: begin
          busy_cnt_r <= busy_cnt_r + 20'h00001;
          if (!stall_s) begin
            state_r <= S_FIN;
          end else if (busy_cnt_r == PROG_TIMEOUT[`FSPS_TIMER_W-1:0]) begin
            ERR_CODE <= fsps_pkg::FSPS_ERR_TIMEOUT;
            state_r <= S_FAIL;
          end
        end
        S_SETTLE: begin
          // Let the armed enable bit expire before the next command
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'(`FSPS_ARM_WINDOW)) begin
            state_r <= S_FIN;
          end
        end
        S_FIN: begin
          ERR_CODE <= fsps_pkg::FSPS_ERR_NONE;
          state_r <= S_IDLE;
        end
        S_FAIL: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Device-facing outputs

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      SPM_CTRL_WE <= 1'b0;
      SPM_CTRL_DATA <= `FSPS_CTRL_IDLE;
      SPM_STROBE <= 1'b0;
      SPM_POINTER <= '0;
      SPM_DATA_PAIR <= '0;
      IRQ_DISABLE <= 1'b0;
    end else begin
      SPM_CTRL_WE <= (state_r == S_ARM);
      SPM_STROBE <= (state_r == S_GAP) &&
                    (cnt_r == 4'(`FSPS_ARM_GAP - 1));
      if (state_r == S_ARM) begin
        SPM_CTRL_DATA <= ctrl_nxt;
        SPM_POINTER <= ptr_nxt;
        SPM_DATA_PAIR <= cmd_r.data;
      end
      // Mask from the check until the store has been issued
      if (state_r == S_CHECK && err_nxt == fsps_pkg::FSPS_ERR_NONE) begin
        IRQ_DISABLE <= 1'b1;
      end else if (state_r == S_STRB || state_r == S_FIN ||
                   state_r == S_FAIL) begin
        IRQ_DISABLE <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // User-facing outputs

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      CMD_READY <= 1'b0;
      DONE <= 1'b0;
      ERROR <= 1'b0;
      BUF_LOST <= 1'b0;
    end else begin
      CMD_READY <= (state_r == S_IDLE) && !CMD_VALID;
      DONE <= (state_r == S_FIN);
      ERROR <= (state_r == S_FAIL);
      BUF_LOST <= lost;
    end
  end

endmodule

// ### core/fsps_defines.svh
// Constants of the flash self-program host sequencer.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef FSPS_DEFINES_SVH
`define FSPS_DEFINES_SVH

// Control register field positions
`define FSPS_BIT_ENABLE 0
`define FSPS_BIT_ERASE 1
`define FSPS_BIT_WRITE 2
`define FSPS_BIT_CLEAR 4

// Control register command values
`define FSPS_CTRL_LOAD 8'h01
`define FSPS_CTRL_ERASE 8'h03
`define FSPS_CTRL_WRITE 8'h05
`define FSPS_CTRL_CLEAR 8'h11
`define FSPS_CTRL_IDLE 8'h00

// Pointer layout
`define FSPS_PTR_W 16
`define FSPS_WORD_W 4
`define FSPS_PAGE_W 9
`define FSPS_PTR_WORD_LSB 1
`define FSPS_PTR_PAGE_LSB (`FSPS_PTR_WORD_LSB + `FSPS_WORD_W)
`define FSPS_BLOCK_LOW_W 2

// Timing
`define FSPS_ARM_WINDOW 4
`define FSPS_ARM_GAP 2
`define FSPS_STALL_WAIT 8
`define FSPS_CLK_PERIOD_NS 10
`define FSPS_PROG_MAX_NS 4500000
`define FSPS_PROG_TIMEOUT (`FSPS_PROG_MAX_NS / `FSPS_CLK_PERIOD_NS)
`define FSPS_TIMER_W 20

`endif

// ### core/fsps_pkg.sv
// Types of the flash self-program host sequencer.
// Assumes fsps_defines.svh is on the include path.
`include "fsps_defines.svh"

package fsps_pkg;

  typedef enum logic [1:0] {
    FSPS_OP_LOAD,
    FSPS_OP_ERASE,
    FSPS_OP_WRITE,
    FSPS_OP_CLEAR
  } fsps_op_e;

  typedef enum logic [2:0] {
    FSPS_ERR_NONE,
    FSPS_ERR_FUSE,
    FSPS_ERR_NOT_ERASED,
    FSPS_ERR_DUP_WORD,
    FSPS_ERR_NO_STALL,
    FSPS_ERR_TIMEOUT
  } fsps_err_e;

  typedef struct packed {
    fsps_op_e op;
    logic [`FSPS_PAGE_W-1:0] page;
    logic [`FSPS_WORD_W-1:0] word;
    logic [15:0] data;
  } fsps_cmd_s;

endpackage

// ### core/fsps_sync.sv
// Two-flop synchroniser for a group of level inputs.
// Assumes the inputs are quasi-static levels from outside the clock.
`timescale 1ns/10ps

module fsps_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// ### core/fsps_track.sv
// Mirror of buffer words loaded and flash pages erased.
// Assumes one update strobe per cycle from the sequencer, except clr_words raised with wr_page.
`timescale 1ns/10ps
`include "fsps_defines.svh"

module fsps_track #(
  parameter int WORD_BITS = `FSPS_WORD_W,
  parameter int PAGE_BITS = `FSPS_PAGE_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Updates
  input wire logic clr_words,
  input wire logic set_word,
  input wire logic erase_blk,
  input wire logic wr_page,
  input wire logic ee_busy,
  input wire logic [WORD_BITS-1:0] word_idx,
  input wire logic [PAGE_BITS-1:0] page_idx,
  // Queries
  output logic word_hit,
  output logic page_ok,
  output logic lost
);

  localparam int NWORDS = 2 ** WORD_BITS;
  localparam int NPAGES = 2 ** PAGE_BITS;

  logic [NWORDS-1:0] words_r;
  logic pages_r [0:NPAGES-1];

  assign word_hit = words_r[word_idx];
  assign page_ok = pages_r[page_idx];
  // The device drops loaded words when an EEPROM write runs
  assign lost = ee_busy && (|words_r);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      words_r <= '0;
    end else if (clr_words || lost) begin
      words_r <= '0;
    end else if (set_word) begin
      words_r[word_idx] <= 1'b1;
    end
  end

  // A written page needs a new erase before it may be written again
  genvar g;
  generate
    for (g = 0; g < NPAGES; g = g + 1) begin : g_page
      localparam logic [PAGE_BITS-1:0] PIDX = PAGE_BITS'(g);
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          pages_r[g] <= 1'b0;
        end else if (erase_blk && (PIDX[PAGE_BITS-1:`FSPS_BLOCK_LOW_W] ==
                     page_idx[PAGE_BITS-1:`FSPS_BLOCK_LOW_W])) begin
          pages_r[g] <= 1'b1;
        end else if (wr_page && (PIDX == page_idx)) begin
          pages_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// ### bench/fsps_props.sv
// Concurrent checks on the device-side pins of the host sequencer.
// Assumes one clock domain; bound onto every fsps_host instance.
`timescale 1ns/10ps
`include "fsps_defines.svh"

module fsps_props #(
  parameter int unsigned PROG_TIMEOUT = `FSPS_PROG_TIMEOUT
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // Watched pins
  input wire logic DONE,
  input wire logic SPM_CTRL_WE,
  input wire logic [7:0] SPM_CTRL_DATA,
  input wire logic SPM_STROBE,
  input wire logic [`FSPS_PTR_W-1:0] SPM_POINTER,
  input wire logic IRQ_DISABLE,
  input wire logic CORE_STALL,
  input wire logic EE_BUSY,
  input wire logic SELF_PROG_FUSE_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  //////////////////////////////////////////////////////////////////////////
  // Inputs pass two flops and the write is registered once more,
  // so busy must stand five samples before a control write is wrong
  sequence s_ee_held;
    EE_BUSY [*5];
  endsequence
  sequence s_stall_held;
    CORE_STALL [*4];
  endsequence

  store_window_a:
    assert property (SPM_CTRL_WE && SPM_CTRL_DATA != `FSPS_CTRL_CLEAR
      |-> ##2 SPM_STROBE) else $error("store missed its window");
  ctrl_code_a:
    assert property (SPM_CTRL_WE |-> SPM_CTRL_DATA inside {`FSPS_CTRL_LOAD,
      `FSPS_CTRL_ERASE, `FSPS_CTRL_WRITE, `FSPS_CTRL_CLEAR})
      else $error("bad control value");
  erase_addr_a:
    assert property (SPM_STROBE && SPM_CTRL_DATA == `FSPS_CTRL_ERASE
      |-> SPM_POINTER[6:0] == 7'h00) else $error("erase pointer low bits");
  write_addr_a:
    assert property (SPM_STROBE && SPM_CTRL_DATA == `FSPS_CTRL_WRITE
      |-> SPM_POINTER[4:0] == 5'h00) else $error("write pointer low bits");
  ptr_spare_a:
    assert property (SPM_STROBE |-> !SPM_POINTER[0]
      && SPM_POINTER[15:14] == 2'h0) else $error("pointer spare bits");
  irq_mask_a:
    assert property (SPM_CTRL_WE && SPM_CTRL_DATA != `FSPS_CTRL_CLEAR
      |-> IRQ_DISABLE [*3]) else $error("interrupts open in window");
  ee_block_a:
    assert property (s_ee_held |-> !SPM_CTRL_WE)
      else $error("control written while eeprom busy");
  fuse_block_a:
    assert property (SELF_PROG_FUSE_N [*8] |-> !SPM_CTRL_WE && !SPM_STROBE)
      else $error("command sent with fuse off");
  stall_hold_a:
    assert property (s_stall_held |-> !DONE && !SPM_STROBE)
      else $error("activity during stall");
endmodule

bind fsps_host fsps_props #(.PROG_TIMEOUT(PROG_TIMEOUT)) u_fsps_props (.*);

// ### bench/fsps_dev_model.sv
// Behavioural self-programming flash unit facing the host sequencer.
// Assumes the bench drives eeprom busy, fuse and the stall length.
`timescale 1ns/10ps

module fsps_dev_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Host pins
  input wire logic ctrl_we,
  input wire logic [7:0] ctrl_data,
  input wire logic strobe,
  input wire logic [15:0] ptr,
  input wire logic [15:0] pair,
  // Environment; a zero stall length means the unit never halts the core
  input wire logic ee_busy,
  input wire logic fuse_n,
  input wire logic [9:0] stall_len,
  output logic stall
);
  logic [15:0] flash [0:8191];
  logic [15:0] buf_r [0:15];
  logic [15:0] buf_ok_r;
  logic [7:0] ctrl_r;
  logic [2:0] win_r;
  logic [9:0] busy_r;
  logic [8:0] tgt_r;
  int n_store;

  initial begin
    for (int i = 0; i < 8192; i++) begin
      flash[i] = 16'h0000;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= 8'h00;
      win_r <= 3'h0;
      busy_r <= 10'h000;
      buf_ok_r <= 16'h0000;
      stall <= 1'h0;
      n_store <= 0;
    end else begin
      if (win_r != 3'h0) begin
        win_r <= win_r - 3'h1;
      end else if (busy_r == 10'h000) begin
        ctrl_r <= 8'h00;
      end
      if (ee_busy) begin
        buf_ok_r <= 16'h0000;
      end
      if (busy_r != 10'h000) begin
        busy_r <= busy_r - 10'h001;
      end
      if (busy_r == 10'h001) begin
        stall <= 1'h0;
        ctrl_r <= 8'h00;
        for (int i = 0; i < 64; i++) begin
          if (!ctrl_r[2]) begin
            flash[{tgt_r[8:2], i[5:0]}] <= 16'hFFFF;
          end
        end
        for (int i = 0; i < 16; i++) begin
          if (ctrl_r[2]) begin
            flash[{tgt_r, i[3:0]}] <= buf_ok_r[i] ? buf_r[i] : 16'hFFFF;
          end
        end
        if (ctrl_r[2]) begin
          buf_ok_r <= 16'h0000;
        end
      end
      if (ctrl_we && !ee_busy) begin
        ctrl_r <= ctrl_data;
        win_r <= 3'h4;
        if (ctrl_data[4]) begin
          buf_ok_r <= 16'h0000;
        end
      end else if (strobe && ctrl_r[0] && win_r != 3'h0 && !fuse_n) begin
        n_store <= n_store + 1;
        win_r <= 3'h0;
        if (ctrl_r[2:1] == 2'h0) begin
          buf_r[ptr[4:1]] <= pair;
          buf_ok_r[ptr[4:1]] <= 1'h1;
          ctrl_r <= 8'h00;
        end else if (stall_len != 10'h000) begin
          tgt_r <= ptr[13:5];
          busy_r <= stall_len;
          stall <= 1'h1;
        end
      end
    end
  end
endmodule

// ### bench/testbench.sv
// Self-checking bench for the flash self-program host sequencer.
// Assumes the device model and the checker are compiled before it.
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end

module testbench;
  localparam fsps_pkg::fsps_op_e LD = fsps_pkg::FSPS_OP_LOAD;
  localparam fsps_pkg::fsps_op_e ER = fsps_pkg::FSPS_OP_ERASE;
  localparam fsps_pkg::fsps_op_e WR = fsps_pkg::FSPS_OP_WRITE;
  localparam fsps_pkg::fsps_err_e OK = fsps_pkg::FSPS_ERR_NONE;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic cmd_valid = 1'h0;
  logic ee_busy = 1'h0;
  logic fuse_n = 1'h1;
  logic [9:0] stall_len = 10'h014;
  fsps_pkg::fsps_cmd_s cmd = '0;
  fsps_pkg::fsps_err_e err_code;
  logic cmd_ready, done, error, buf_lost, we, strobe, irq_off, stall;
  logic [7:0] ctrl;
  logic [15:0] ptr, pair;
  logic lost_seen;
  int fails = 0;
  int cmp_count = 0;
  int s;

  fsps_host #(.PROG_TIMEOUT(200)) u_fsps_host (.CLK(clk), .RESETN(resetn),
    .CMD_VALID(cmd_valid), .CMD(cmd), .CMD_READY(cmd_ready), .DONE(done),
    .ERROR(error), .ERR_CODE(err_code), .BUF_LOST(buf_lost),
    .SPM_CTRL_WE(we), .SPM_CTRL_DATA(ctrl), .SPM_STROBE(strobe),
    .SPM_POINTER(ptr), .SPM_DATA_PAIR(pair), .IRQ_DISABLE(irq_off),
    .CORE_STALL(stall), .EE_BUSY(ee_busy), .SELF_PROG_FUSE_N(fuse_n));
  fsps_dev_model u_fsps_dev_model (.clk(clk), .resetn(resetn),
    .ctrl_we(we), .ctrl_data(ctrl), .strobe(strobe), .ptr(ptr),
    .pair(pair), .ee_busy(ee_busy), .fuse_n(fuse_n),
    .stall_len(stall_len), .stall(stall));

  initial begin
    forever #5 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic run(input fsps_pkg::fsps_op_e op, input logic [8:0] pg,
      input logic [3:0] wd, input logic [15:0] dt,
      input fsps_pkg::fsps_err_e exp);
    int n;
    n = 0;
    while (cmd_ready !== 1'h1 && n < 50) begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk);
    cmd_valid <= 1'h1;
    cmd <= '{op: op, page: pg, word: wd, data: dt};
    @(posedge clk);
    cmd_valid <= 1'h0;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (done !== 1'h1 && error !== 1'h1 && n < 600);
    `CHK("answered", 1'h1, done | error)
    `CHK("result", exp, done === 1'h1 ? OK : err_code)
  endtask

  task automatic t_fill_first();
    s = u_fsps_dev_model.n_store;
    run(LD, 9'h05A, 4'h1, 16'h1234, fsps_pkg::FSPS_ERR_FUSE);
    `CHK("stores", s, u_fsps_dev_model.n_store)
    @(posedge clk);
    fuse_n <= 1'h0;
    run(LD, 9'h05A, 4'h9, 16'hA509, OK);
    run(LD, 9'h05A, 4'h2, 16'h5A02, OK);
    run(ER, 9'h05A, 4'h7, 16'hDEAD, OK);
    run(WR, 9'h05A, 4'h0, 16'h0000, OK);
    `CHK("word9", 16'hA509, u_fsps_dev_model.flash[13'h05A9])
    `CHK("word2", 16'h5A02, u_fsps_dev_model.flash[13'h05A2])
    `CHK("blank", 16'hFFFF, u_fsps_dev_model.flash[13'h05A0])
    `CHK("mate", 16'hFFFF, u_fsps_dev_model.flash[13'h058F])
    `CHK("outside", 16'h0000, u_fsps_dev_model.flash[13'h05C0])
  endtask

  task automatic t_erase_first();
    run(ER, 9'h101, 4'h0, 16'h0000, OK);
    run(LD, 9'h102, 4'h3, 16'h0C03, OK);
    run(WR, 9'h102, 4'h0, 16'h0000, OK);
    `CHK("word3", 16'h0C03, u_fsps_dev_model.flash[13'h1023])
    `CHK("old word9", 16'hFFFF, u_fsps_dev_model.flash[13'h1029])
    run(WR, 9'h102, 4'h0, 16'h0000, fsps_pkg::FSPS_ERR_NOT_ERASED);
  endtask

  task automatic t_dup_clear();
    run(LD, 9'h103, 4'h1, 16'h1111, OK);
    run(LD, 9'h103, 4'h1, 16'h2222, fsps_pkg::FSPS_ERR_DUP_WORD);
    run(fsps_pkg::FSPS_OP_CLEAR, 9'h103, 4'h0, 16'h0000, OK);
    `CHK("cleared", 16'h0000, u_fsps_dev_model.buf_ok_r)
    run(LD, 9'h103, 4'h1, 16'h3333, OK);
  endtask

  task automatic t_ee_block();
    lost_seen = 1'h0;
    @(posedge clk);
    ee_busy <= 1'h1;
    repeat (10) begin
      @(posedge clk);
      #1 lost_seen |= buf_lost;
    end
    `CHK("lost", 1'h1, lost_seen)
    `CHK("dropped", 16'h0000, u_fsps_dev_model.buf_ok_r)
    s = u_fsps_dev_model.n_store;
    fork
      begin
        repeat (30) @(posedge clk);
        ee_busy <= 1'h0;
      end
    join_none
    run(LD, 9'h103, 4'h4, 16'h4444, OK);
    `CHK("stores", s + 1, u_fsps_dev_model.n_store)
  endtask

  task automatic t_stall_faults();
    @(posedge clk);
    stall_len <= 10'h000;
    run(ER, 9'h120, 4'h0, 16'h0000, fsps_pkg::FSPS_ERR_NO_STALL);
    @(posedge clk);
    stall_len <= 10'h12C;
    run(ER, 9'h124, 4'h0, 16'h0000, fsps_pkg::FSPS_ERR_TIMEOUT);
    repeat (120) @(posedge clk);
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'h1;
    t_fill_first();
    t_erase_first();
    t_dup_clear();
    t_ee_block();
    t_stall_faults();
    stop_test();
  end

  // Whole run needs under a thousand cycles; this limit only cuts a hang
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test();
  end
endmodule
